// ### hdl/dmacca_defines.svh
`ifndef DMACCA_DEFINES_SVH
`define DMACCA_DEFINES_SVH

// ----------------------------------------
// controller layout (register indexes, byte address = index * 4)
// ----------------------------------------
`define DMACCA_NUM_CH 4
`define DMACCA_STATUS_IDX 8'h04
`define DMACCA_TEMPL_IDX 8'h06
`define DMACCA_TEMPH_IDX 8'h07
`define DMACCA_CH_FIRST 4'h1
`define DMACCA_CH_LAST 4'h4
`define DMACCA_UNMAPPED_IDX 8'hFF

// ----------------------------------------
// channel window (index within each 16-entry window)
// ----------------------------------------
`define DMACCA_CTRL_OFS 4'h0
`define DMACCA_BUSY_OFS 4'h1
`define DMACCA_STEP_OFS 4'h2
`define DMACCA_CNTL_OFS 4'h4
`define DMACCA_CNTH_OFS 4'h5
`define DMACCA_REP_OFS 4'h6
`define DMACCA_SRC0_OFS 4'h8
`define DMACCA_SRC1_OFS 4'h9
`define DMACCA_SRC2_OFS 4'hA
`define DMACCA_DST0_OFS 4'hC
`define DMACCA_DST1_OFS 4'hD
`define DMACCA_DST2_OFS 4'hE

// ----------------------------------------
// field positions
// ----------------------------------------
`define DMACCA_CTRL_EN_BIT 7
`define DMACCA_CTRL_RPT_BIT 5
`define DMACCA_CTRL_REQ_BIT 4
`define DMACCA_BUSY_BIT 7
`define DMACCA_SRC_STEP_LSB 4
`define DMACCA_DST_STEP_LSB 0
`define DMACCA_STATUS_BUSY_LSB 4

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define DMACCA_COUNT_RST 16'h0001
`define DMACCA_COUNT_ZERO_LEN 16'hFFFF
`define DMACCA_REP_RST 8'h00
`define DMACCA_PTR_RST 24'h00_0000
`define DMACCA_STEP_FIXED 2'h0
`define DMACCA_STEP_INC 2'h1
`define DMACCA_STEP_DEC 2'h2

`endif

// ### hdl/dmacca_pkg.sv
package dmacca_pkg;
`include "dmacca_defines.svh"

    // ----------------------------------------
    // data engine states
    // ----------------------------------------
    typedef enum logic [1:0] {
        DMACCA_IDLE,
        DMACCA_READ,
        DMACCA_WRITE
    } dmacca_fsm_t;

    // ----------------------------------------
    // per-channel counting and addressing state
    // ----------------------------------------
    typedef struct packed {
        logic enable;
        logic repeat_en;
        logic busy;
        logic req_pend;
        logic [1:0] src_mode;
        logic [1:0] dst_mode;
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0] repeat_cnt;
        logic [23:0] src;
        logic [23:0] dst;
    } dmacca_chan_t;

    // ----------------------------------------
    // whole controller state
    // ----------------------------------------
    typedef struct packed {
        dmacca_chan_t [`DMACCA_NUM_CH-1:0] ch;
        logic [15:0] temp;
        logic rd_pend;
        logic wr_pend;
        logic [7:0] idx;
        logic [31:0] rdata;
        dmacca_fsm_t fsm;
        logic [1:0] act;
        logic blk_last;
        logic [23:0] bus_addr;
        logic [7:0] bus_data;
        logic [`DMACCA_NUM_CH-1:0] trig_prev;
    } dmacca_state_t;

    typedef struct packed {
        logic [`DMACCA_NUM_CH-1:0] meta;
        logic [`DMACCA_NUM_CH-1:0] sync;
    } dmacca_sync_state_t;

endpackage

// ### hdl/dmacca_sync.sv
`timescale 1ns/100ps
`include "dmacca_defines.svh"
// two-flop synchroniser for the trigger pins
module dmacca_sync
    import dmacca_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [`DMACCA_NUM_CH-1:0] async_in,
    output logic [`DMACCA_NUM_CH-1:0] sync_out
);
    dmacca_sync_state_t s_reg;
    dmacca_sync_state_t s_next;

    // first stage feeds only the second stage
    always_comb begin
        s_next = s_reg;
        s_next.meta = async_in;
        s_next.sync = s_reg.meta;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.sync;
endmodule

// ### hdl/dmacca_step.sv
`timescale 1ns/100ps
`include "dmacca_defines.svh"
// next value of a 24-bit pointer for its step mode
module dmacca_step
    import dmacca_pkg::*;
(
    input wire logic [23:0] ptr_in,
    input wire logic [1:0] mode_in,
    output logic [23:0] ptr_out
);
    // reserved code holds the pointer like fixed mode
    always_comb begin
        unique case (mode_in)
            `DMACCA_STEP_INC: ptr_out = ptr_in + 24'h00_0001;
            `DMACCA_STEP_DEC: ptr_out = ptr_in - 24'h00_0001;
            default: ptr_out = ptr_in;
        endcase
    end
endmodule

// ### hdl/dmacca_top.sv
`timescale 1ns/100ps
`include "dmacca_defines.svh"
module dmacca_top
    import dmacca_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic [`DMACCA_NUM_CH-1:0] TRIG_IN,
    output logic DMEM_REQ_OUT,
    output logic DMEM_WE_OUT,
    output logic [23:0] DMEM_ADDR_OUT,
    output logic [7:0] DMEM_WDATA_OUT,
    input wire logic [7:0] DMEM_RDATA_IN,
    input wire logic DMEM_ACK_IN,
    output logic [`DMACCA_NUM_CH-1:0] CH_BUSY_OUT
);
    // one state struct
    dmacca_state_t s_reg;
    dmacca_state_t s_next;

    // synchronised triggers
    logic [`DMACCA_NUM_CH-1:0] trig_sync;
    // next pointer values
    logic [23:0] src_stepped [`DMACCA_NUM_CH];
    logic [23:0] dst_stepped [`DMACCA_NUM_CH];
    logic accept;

    // ----------------------------------------
    // trigger pins and pointer steppers
    // ----------------------------------------
    dmacca_sync u_sync (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .async_in(TRIG_IN),
        .sync_out(trig_sync)
    );


    // a stepper per pointer
    genvar gi;
    generate
        for (gi = 0; gi < `DMACCA_NUM_CH; gi++) begin : g_ch
            // source side
            dmacca_step u_src (
                .ptr_in(s_reg.ch[gi].src),
                .mode_in(s_reg.ch[gi].src_mode),
                .ptr_out(src_stepped[gi])
            );
            // destination side
            dmacca_step u_dst (
                .ptr_in(s_reg.ch[gi].dst),
                .mode_in(s_reg.ch[gi].dst_mode),
                .ptr_out(dst_stepped[gi])
            );
            // busy from the register
            assign CH_BUSY_OUT[gi] = s_reg.ch[gi].busy;
        end
    endgenerate

    // ----------------------------------------
    // ahb-lite address phase
    // ----------------------------------------
    // only nonseq/seq transfers are taken; idle and busy are ignored
    assign accept = HSEL_IN & HREADY_IN & HTRANS_IN[1];

    // ----------------------------------------
    // register read value, no side effects here
    // ----------------------------------------
    function automatic logic [7:0] read_val(input dmacca_state_t s);
        logic [7:0] v;
        logic [1:0] c;
        logic [3:0] o;
        v = 8'h00;
        c = 2'(s.idx[7:4] - `DMACCA_CH_FIRST);
        o = s.idx[3:0];

        // status: all busy bits
        if (s.idx == `DMACCA_STATUS_IDX) begin
            for (int i = 0; i < `DMACCA_NUM_CH; i++) begin
                v[`DMACCA_STATUS_BUSY_LSB + i] = s.ch[i].busy;
            end
        end else if (s.idx == `DMACCA_TEMPL_IDX) begin
            v = s.temp[7:0];
        end else if (s.idx == `DMACCA_TEMPH_IDX) begin
            v = s.temp[15:8];
        end else if (s.idx[7:4] >= `DMACCA_CH_FIRST && s.idx[7:4] <= `DMACCA_CH_LAST) begin
            unique case (o)
                `DMACCA_CTRL_OFS: begin
                    v[`DMACCA_CTRL_EN_BIT] = s.ch[c].enable;
                    v[`DMACCA_CTRL_RPT_BIT] = s.ch[c].repeat_en;
                end
                `DMACCA_BUSY_OFS: v[`DMACCA_BUSY_BIT] = s.ch[c].busy;
                `DMACCA_STEP_OFS: begin
                    v[`DMACCA_SRC_STEP_LSB +: 2] = s.ch[c].src_mode;
                    v[`DMACCA_DST_STEP_LSB +: 2] = s.ch[c].dst_mode;
                end
                `DMACCA_CNTL_OFS: v = s.ch[c].count[7:0];
                // upper bytes from temp
                `DMACCA_CNTH_OFS: v = s.temp[7:0];
                `DMACCA_REP_OFS: v = s.ch[c].repeat_cnt;
                `DMACCA_SRC0_OFS: v = s.ch[c].src[7:0];
                `DMACCA_SRC1_OFS: v = s.temp[7:0];
                `DMACCA_SRC2_OFS: v = s.temp[15:8];
                `DMACCA_DST0_OFS: v = s.ch[c].dst[7:0];
                `DMACCA_DST1_OFS: v = s.temp[7:0];
                `DMACCA_DST2_OFS: v = s.temp[15:8];
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    // ----------------------------------------
    // next state: start, data engine, then software access
    // ----------------------------------------
    // software access is applied last, so a bus write wins over the
    // engine on the same register in the same cycle
    always_comb begin
        logic found;
        logic [1:0] pick;
        logic [1:0] a;
        logic [1:0] c;
        logic [3:0] o;
        logic [7:0] d;
        logic [15:0] len;
        logic in_win;
        found = 1'b0;
        pick = 2'h0;
        a = s_reg.act;
        c = 2'(s_reg.idx[7:4] - `DMACCA_CH_FIRST);
        o = s_reg.idx[3:0];
        d = HWDATA_IN[7:0];
        len = {d, s_reg.temp[7:0]};
        in_win = (s_reg.idx[7:4] >= `DMACCA_CH_FIRST) && (s_reg.idx[7:4] <= `DMACCA_CH_LAST);

        // hold unless changed below
        s_next = s_reg;
        s_next.trig_prev = trig_sync;

        // a software request or a trigger edge opens a transaction
        // an edge while busy is dropped
        for (int i = 0; i < `DMACCA_NUM_CH; i++) begin
            if (s_reg.ch[i].enable && !s_reg.ch[i].busy
                && (s_reg.ch[i].req_pend || (trig_sync[i] && !s_reg.trig_prev[i]))) begin
                s_next.ch[i].busy = 1'b1;
                s_next.ch[i].req_pend = 1'b0;
            end
        end

        // one byte at a time: read source, then write destination
        unique case (s_reg.fsm)
            DMACCA_IDLE: begin
                // lowest busy channel wins; scanned high to low
                for (int i = `DMACCA_NUM_CH - 1; i >= 0; i--) begin
                    if (s_reg.ch[i].busy) begin
                        found = 1'b1;
                        pick = 2'(i);
                    end
                end
                if (found) begin
                    s_next.act = pick;
                    s_next.bus_addr = s_reg.ch[pick].src;
                    s_next.fsm = DMACCA_READ;
                end
            end
            DMACCA_READ: begin
                if (DMEM_ACK_IN) begin
                    // held for the write
                    s_next.bus_data = DMEM_RDATA_IN;
                    // steps once per byte read
                    s_next.ch[a].src = src_stepped[a];
                    // last byte: reload, block ends at its write
                    if (s_reg.ch[a].count == `DMACCA_COUNT_RST) begin
                        s_next.ch[a].count = s_reg.ch[a].reload;
                        s_next.blk_last = 1'b1;
                    end else begin
                        s_next.ch[a].count = s_reg.ch[a].count - 16'h0001;
                    end
                    s_next.bus_addr = s_reg.ch[a].dst;
                    s_next.fsm = DMACCA_WRITE;
                end
            end
            DMACCA_WRITE: begin
                if (DMEM_ACK_IN) begin
                    s_next.ch[a].dst = dst_stepped[a];
                    s_next.fsm = DMACCA_IDLE;
                    // once per block
                    if (s_reg.blk_last) begin
                        s_next.blk_last = 1'b0;
                        if (s_reg.ch[a].repeat_en) begin
                            if (s_reg.ch[a].repeat_cnt == 8'h01) begin
                                s_next.ch[a].repeat_cnt = 8'h00;
                                s_next.ch[a].busy = 1'b0;
                                s_next.ch[a].enable = 1'b0;
                            end else if (s_reg.ch[a].repeat_cnt != 8'h00) begin
                                s_next.ch[a].repeat_cnt = s_reg.ch[a].repeat_cnt - 8'h01;
                            end
                            // zero count keeps repeating
                        end else begin
                            if (s_reg.ch[a].repeat_cnt != 8'h00) begin
                                s_next.ch[a].repeat_cnt = s_reg.ch[a].repeat_cnt - 8'h01;
                            end
                            s_next.ch[a].busy = 1'b0;
                            s_next.ch[a].enable = 1'b0;
                        end
                    end
                end
            end
            default: s_next.fsm = DMACCA_IDLE;
        endcase

        // read data phase: register the byte, latch upper bytes in temp
        if (s_reg.rd_pend) begin
            s_next.rdata = {24'h00_0000, read_val(s_reg)};
            if (in_win) begin
                unique case (o)
                    `DMACCA_CNTL_OFS: s_next.temp[7:0] = s_reg.ch[c].count[15:8];
                    `DMACCA_SRC0_OFS: s_next.temp = s_reg.ch[c].src[23:8];
                    `DMACCA_DST0_OFS: s_next.temp = s_reg.ch[c].dst[23:8];
                    default: ;
                endcase
            end
        end

        // write data phase: low bytes park in temp, top byte commits
        if (s_reg.wr_pend) begin
            if (s_reg.idx == `DMACCA_TEMPL_IDX) begin
                s_next.temp[7:0] = d;
            end else if (s_reg.idx == `DMACCA_TEMPH_IDX) begin
                s_next.temp[15:8] = d;
            end else if (in_win) begin
                unique case (o)
                    // clearing enable does not abort
                    `DMACCA_CTRL_OFS: begin
                        s_next.ch[c].enable = d[`DMACCA_CTRL_EN_BIT];
                        s_next.ch[c].repeat_en = d[`DMACCA_CTRL_RPT_BIT];
                        if (d[`DMACCA_CTRL_REQ_BIT]) begin
                            s_next.ch[c].req_pend = 1'b1;
                        end
                    end
                    `DMACCA_STEP_OFS: begin
                        // modes are frozen during a transaction
                        if (!s_reg.ch[c].busy) begin
                            s_next.ch[c].src_mode = d[`DMACCA_SRC_STEP_LSB +: 2];
                            s_next.ch[c].dst_mode = d[`DMACCA_DST_STEP_LSB +: 2];
                        end
                    end
                    `DMACCA_CNTL_OFS: s_next.temp[7:0] = d;
                    `DMACCA_CNTH_OFS: begin
                        // zero kept as longest block
                        s_next.ch[c].reload = (len == 16'h0000) ? `DMACCA_COUNT_ZERO_LEN : len;
                        s_next.ch[c].count = (len == 16'h0000) ? `DMACCA_COUNT_ZERO_LEN : len;
                    end
                    `DMACCA_REP_OFS: s_next.ch[c].repeat_cnt = d;
                    // low bytes park, top byte commits
                    `DMACCA_SRC0_OFS: s_next.temp[7:0] = d;
                    `DMACCA_SRC1_OFS: s_next.temp[15:8] = d;
                    `DMACCA_SRC2_OFS: s_next.ch[c].src = {d, s_reg.temp};
                    `DMACCA_DST0_OFS: s_next.temp[7:0] = d;
                    `DMACCA_DST1_OFS: s_next.temp[15:8] = d;
                    `DMACCA_DST2_OFS: s_next.ch[c].dst = {d, s_reg.temp};
                    default: ;
                endcase
            end
        end

        // capture the next address phase; reads take one wait state
        s_next.rd_pend = accept & ~HWRITE_IN;
        s_next.wr_pend = accept & HWRITE_IN;
        if (accept) begin
            s_next.idx = (HADDR_IN[31:10] == 22'h00_0000) ? HADDR_IN[9:2] : `DMACCA_UNMAPPED_IDX;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // reset branch holds constants only
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s_reg <= '0;
            for (int i = 0; i < `DMACCA_NUM_CH; i++) begin
                s_reg.ch[i].count <= `DMACCA_COUNT_RST;
                s_reg.ch[i].reload <= `DMACCA_COUNT_RST;
                s_reg.ch[i].repeat_cnt <= `DMACCA_REP_RST;
                s_reg.ch[i].src <= `DMACCA_PTR_RST;
                s_reg.ch[i].dst <= `DMACCA_PTR_RST;
            end
            s_reg.fsm <= DMACCA_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // register bus
    assign HRDATA_OUT = s_reg.rdata;
    assign HREADYOUT_OUT = ~s_reg.rd_pend;
    // no error response
    assign HRESP_OUT = 1'b0;

    // data bus
    assign DMEM_REQ_OUT = (s_reg.fsm != DMACCA_IDLE);
    assign DMEM_WE_OUT = (s_reg.fsm == DMACCA_WRITE);
    assign DMEM_ADDR_OUT = s_reg.bus_addr;
    assign DMEM_WDATA_OUT = s_reg.bus_data;
endmodule

// ### test/dmacca_top_sva.sv
`timescale 1ns/100ps
`include "dmacca_defines.svh"
// ----------------------------------------
// register bus and data bus checks
// ----------------------------------------
module dmacca_top_sva
    import dmacca_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic HSEL_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic DMEM_REQ_OUT,
    input wire logic DMEM_WE_OUT,
    input wire logic [23:0] DMEM_ADDR_OUT,
    input wire logic [7:0] DMEM_WDATA_OUT,
    input wire logic [7:0] DMEM_RDATA_IN,
    input wire logic DMEM_ACK_IN,
    input wire logic [3:0] CH_BUSY_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // taken address phases and completed data bus beats
    wire take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    wire rd_done = DMEM_REQ_OUT && !DMEM_WE_OUT && DMEM_ACK_IN;
    wire wr_done = DMEM_REQ_OUT && DMEM_WE_OUT && DMEM_ACK_IN;
    read_wait_a: assert property (take && !HWRITE_IN |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
        else $error("read data phase not one wait state");
    write_nowait_a: assert property (take && HWRITE_IN |=> HREADYOUT_OUT)
        else $error("write data phase stalled");
    resp_okay_a: assert property (HRESP_OUT == 1'b0)
        else $error("bus response not okay");
    rdata_upper_a: assert property (HRDATA_OUT[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    req_hold_a: assert property (DMEM_REQ_OUT && !DMEM_ACK_IN |=>
        DMEM_REQ_OUT && $stable(DMEM_ADDR_OUT) && $stable(DMEM_WE_OUT))
        else $error("data request changed before ack");
    rd_then_wr_a: assert property (rd_done |=> DMEM_REQ_OUT && DMEM_WE_OUT)
        else $error("byte read not followed by write");
    byte_pass_a: assert property (rd_done |=> DMEM_WDATA_OUT == $past(DMEM_RDATA_IN))
        else $error("written byte differs from read byte");
    idle_gap_a: assert property (wr_done |=> !DMEM_REQ_OUT)
        else $error("no idle cycle after byte write");
    busy_start_a: assert property ($rose(DMEM_REQ_OUT) |-> CH_BUSY_OUT != 4'h0)
        else $error("data request with no busy channel");
endmodule

bind dmacca_top dmacca_top_sva u_sva(.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
    .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .DMEM_REQ_OUT(DMEM_REQ_OUT), .DMEM_WE_OUT(DMEM_WE_OUT), .DMEM_ADDR_OUT(DMEM_ADDR_OUT),
    .DMEM_WDATA_OUT(DMEM_WDATA_OUT), .DMEM_RDATA_IN(DMEM_RDATA_IN),
    .DMEM_ACK_IN(DMEM_ACK_IN), .CH_BUSY_OUT(CH_BUSY_OUT));

// ### test/dmacca_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// byte memory on the data bus, ack after a set delay
// ----------------------------------------
module dmacca_mem_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [23:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] delay_in,
    output logic ack_out,
    output logic [7:0] rdata_out
);
    int wr_cnt;
    logic [23:0] last_addr;
    logic [7:0] last_data;
    logic [7:0] wait_cnt;
    // read byte is a function of the address; between acks the lines keep toggling
    // so a design sampling off the ack edge never sees a plausible byte
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_out <= 1'b0;
            rdata_out <= 8'h00;
            wait_cnt <= 8'h00;
            wr_cnt <= 0;
            last_addr <= 24'h00_0000;
            last_data <= 8'h00;
        end else if (req_in && !ack_out && wait_cnt >= delay_in) begin
            ack_out <= 1'b1;
            rdata_out <= we_in ? ~rdata_out : (addr_in[7:0] ^ 8'h3C);
            wait_cnt <= 8'h00;
        end else begin
            ack_out <= 1'b0;
            rdata_out <= ~rdata_out;
            wait_cnt <= req_in && !ack_out ? wait_cnt + 8'h01 : 8'h00;
            if (ack_out && req_in && we_in) begin
                wr_cnt <= wr_cnt + 1;
                last_addr <= addr_in;
                last_data <= wdata_in;
            end
        end
    end
endmodule

// ### test/dmacca_top_tb.sv
`timescale 1ns/100ps
`include "dmacca_defines.svh"
module dmacca_top_tb;
    import dmacca_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, hwrite = 1'b0, hready, hresp, req, we, ack;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
    logic [3:0] trig = 4'h0, busy;
    logic [23:0] addr;
    logic [7:0] wdata, rdata, dly = 8'h00;
    int failures = 0, checks = 0, base;
    always #5 mclk = ~mclk;
    dmacca_top u_dut(.MCLK_IN(mclk), .SYS_RST_IN(rst), .HSEL_IN(1'b1), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .TRIG_IN(trig), .DMEM_REQ_OUT(req), .DMEM_WE_OUT(we), .DMEM_ADDR_OUT(addr),
        .DMEM_WDATA_OUT(wdata), .DMEM_RDATA_IN(rdata), .DMEM_ACK_IN(ack), .CH_BUSY_OUT(busy));
    dmacca_mem_model u_mem(.clk_in(mclk), .rst_in(rst), .req_in(req), .we_in(we),
        .addr_in(addr), .wdata_in(wdata), .delay_in(dly), .ack_out(ack), .rdata_out(rdata));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic give_verdict();
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one single transfer; entered just after a rising edge, leaves just after one
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        htrans <= 2'b10;
        haddr <= {22'h00_0000, idx, 2'b00};
        hwrite <= w;
        do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 64);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 64);
        r = hrdata;
        if (n >= 64) begin failures++; give_verdict(); end
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00);
        chk(what, {24'h00_0000, exp}, r);
    endtask
    function automatic logic [7:0] ix(input int ch, input logic [3:0] ofs);
        return 8'(16 * (ch + 1) + ofs);
    endfunction
    // 24-bit values go low byte first, the top byte commits the whole value
    task automatic set24(input int ch, input logic [3:0] ofs, input logic [23:0] v);
        for (int i = 0; i < 3; i++) bus(1'b1, ix(ch, ofs + 4'(i)), v[8*i+:8]);
    endtask
    task automatic chk24(input int ch, input logic [3:0] ofs, input logic [23:0] v);
        for (int i = 0; i < 3; i++) rdchk(ix(ch, ofs + 4'(i)), v[8*i+:8], "pointer byte");
    endtask
    task automatic wait_busy(input int ch, input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy[ch] !== lvl && n < lim) begin @(posedge mclk); n++; end
        if (n >= lim) begin failures++; give_verdict(); end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int c = 0; c < 4; c++) begin
            rdchk(ix(c, `DMACCA_CNTL_OFS), 8'h01, "count low");
            rdchk(ix(c, `DMACCA_CNTH_OFS), 8'h00, "count high");
            rdchk(ix(c, `DMACCA_REP_OFS), 8'h00, "repeat count");
            chk24(c, `DMACCA_SRC0_OFS, 24'h00_0000);
            chk24(c, `DMACCA_DST0_OFS, 24'h00_0000);
        end
        rdchk(`DMACCA_UNMAPPED_IDX, 8'h00, "unmapped");
        // zero count, then a low byte alone must not commit
        bus(1'b1, ix(3, `DMACCA_CNTL_OFS), 8'h00);
        bus(1'b1, ix(3, `DMACCA_CNTH_OFS), 8'h00);
        bus(1'b1, ix(3, `DMACCA_CNTL_OFS), 8'h34);
        rdchk(ix(3, `DMACCA_CNTL_OFS), 8'hFF, "zero count low");
        rdchk(ix(3, `DMACCA_CNTH_OFS), 8'hFF, "zero count high");
        // ch0: three bytes, source up, destination down, slow memory
        set24(0, `DMACCA_SRC0_OFS, 24'h12_3456);
        set24(0, `DMACCA_DST0_OFS, 24'h00_ABCD);
        chk24(0, `DMACCA_SRC0_OFS, 24'h12_3456);
        bus(1'b1, ix(0, `DMACCA_CNTL_OFS), 8'h03);
        bus(1'b1, ix(0, `DMACCA_CNTH_OFS), 8'h00);
        bus(1'b1, ix(0, `DMACCA_STEP_OFS), 8'h12);
        dly <= 8'h03;
        bus(1'b1, ix(0, `DMACCA_CTRL_OFS), 8'h90);
        wait_busy(0, 1'b1, 20);
        bus(1'b1, ix(0, `DMACCA_STEP_OFS), 8'h00);
        wait_busy(0, 1'b0, 500);
        chk("byte writes", 3, u_mem.wr_cnt);
        chk("last dest", 32'h0000_ABCB, u_mem.last_addr);
        chk("last byte", 32'h0000_0064, u_mem.last_data);
        chk24(0, `DMACCA_SRC0_OFS, 24'h12_3459);
        chk24(0, `DMACCA_DST0_OFS, 24'h00_ABCA);
        rdchk(ix(0, `DMACCA_CNTL_OFS), 8'h03, "reloaded count");
        rdchk(ix(0, `DMACCA_STEP_OFS), 8'h12, "step locked");
        // ch1: repeat three blocks of two, reserved step code holds pointers
        dly <= 8'h00;
        base = u_mem.wr_cnt;
        set24(1, `DMACCA_SRC0_OFS, 24'h00_0010);
        bus(1'b1, ix(1, `DMACCA_CNTL_OFS), 8'h02);
        bus(1'b1, ix(1, `DMACCA_CNTH_OFS), 8'h00);
        bus(1'b1, ix(1, `DMACCA_REP_OFS), 8'h03);
        bus(1'b1, ix(1, `DMACCA_STEP_OFS), 8'h33);
        bus(1'b1, ix(1, `DMACCA_CTRL_OFS), 8'hB0);
        wait_busy(1, 1'b1, 20);
        wait_busy(1, 1'b0, 500);
        chk("repeat writes", base + 6, u_mem.wr_cnt);
        rdchk(ix(1, `DMACCA_REP_OFS), 8'h00, "repeat left");
        bus(1'b0, ix(1, `DMACCA_CTRL_OFS), 8'h00);
        chk("enable", 32'h0000_0000, {31'h0000_0000, r[7]});
        chk24(1, `DMACCA_SRC0_OFS, 24'h00_0010);
        // ch1 again by trigger pin, no repeat: two bytes, source down, dest up
        bus(1'b1, ix(1, `DMACCA_STEP_OFS), 8'h21);
        bus(1'b1, ix(1, `DMACCA_CTRL_OFS), 8'h80);
        trig <= 4'h2;
        wait_busy(1, 1'b1, 20);
        trig <= 4'h0;
        wait_busy(1, 1'b0, 500);
        chk("trigger writes", base + 8, u_mem.wr_cnt);
        chk24(1, `DMACCA_SRC0_OFS, 24'h00_000E);
        chk24(1, `DMACCA_DST0_OFS, 24'h00_0002);
        // ch2: repeat with counter zero never stops on its own
        bus(1'b1, ix(2, `DMACCA_REP_OFS), 8'h00);
        bus(1'b1, ix(2, `DMACCA_CTRL_OFS), 8'hB0);
        wait_busy(2, 1'b1, 20);
        repeat (300) @(posedge mclk);
        chk("endless busy", 32'h0000_0001, {31'h0000_0000, busy[2]});
        chk("endless runs", 1, u_mem.wr_cnt > base + 20);
        rdchk(`DMACCA_STATUS_IDX, 8'h40, "status busy");
        chk24(2, `DMACCA_SRC0_OFS, 24'h00_0000);
        give_verdict();
    end
endmodule
